// >>> fsps_pkg.sv
/*
 * constants, field positions and types shared by both ends of the flash
 * self-programming sequencer and its processor-side controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package fsps_pkg;
    // array geometry
    localparam int ROW_INSTRS   = 64;
    localparam int ROW_BYTES    = 192;
    localparam int PAGE_ROWS    = 8;
    localparam int PAGE_INSTRS  = 512;
    localparam int PAGE_BYTES   = 1536;
    localparam int FLASH_INSTRS = 4096;
    localparam int FLASH_IDX_W  = 12;
    localparam int BUF_IDX_W    = 6;
    localparam int WALK_W       = 10;
    localparam int WORD_W       = 24;
    localparam int DATA_W       = 16;
    localparam int PAGE_W       = 8;
    localparam int TIMER_W      = 24;
    localparam logic [WORD_W-1:0] ERASED_WORD = 24'hffffff;
    localparam logic [FLASH_IDX_W-1:0] ROW_MASK  = 12'h03f;
    localparam logic [FLASH_IDX_W-1:0] PAGE_MASK = 12'h1ff;

    // control register fields
    localparam int CTRL_START_BIT  = 15;
    localparam int CTRL_ENABLE_BIT = 14;
    localparam int CTRL_OP_LSB     = 0;
    localparam int CTRL_OP_W       = 4;
    localparam logic [DATA_W-1:0]    CTRL_RESET = 16'h0000;
    localparam logic [CTRL_OP_W-1:0] OP_ROW     = 4'h1;
    localparam logic [CTRL_OP_W-1:0] OP_ERASE   = 4'h2;
    localparam logic [CTRL_OP_W-1:0] OP_WORD    = 4'h3;

    // unlock keys and special register select
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'haa;
    localparam logic       SFR_SEL_CTRL = 1'b0;
    localparam logic       SFR_SEL_KEY  = 1'b1;

    // timing in oscillator cycles; NOP_AFTER_START in clock cycles
    localparam int ROW_WRITE_OSC_CYCLES  = 11064;
    localparam int PAGE_ERASE_OSC_CYCLES = 20000;
    localparam int WORD_WRITE_OSC_CYCLES = 400;
    localparam int NOP_AFTER_START       = 2;

    // controller register map (byte addresses)
    localparam int AXI_ADDR_W = 8;
    localparam logic [AXI_ADDR_W-1:0] REG_CMD    = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] REG_ADDR   = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] REG_DATA   = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h0c;
    localparam logic [AXI_ADDR_W-1:0] REG_RDATA  = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] REG_CTRL   = 8'h14;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_TBL_LO, CMD_TBL_HI, CMD_CTRL, CMD_KEY, CMD_TBL_RD, CMD_UNLOCK_START
    } fsps_cmd_t;
    typedef enum logic [1:0] {KEY_LOCKED, KEY_GOT_FIRST, KEY_ARMED} fsps_key_t;
    typedef enum logic {D_IDLE, D_RUN} fsps_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_SETTLE, H_WAIT, H_NOP} fsps_host_state_t;
endpackage : fsps_pkg

// >>> fsps_if.sv
/*
 * link between the processor-side controller and the flash sequencer.
 * assumes both ends run on the same clock; pulses last one cycle.
 */
`timescale 1ns/1ps
interface fsps_if;
    logic        tbl_wr_lo;
    logic        tbl_wr_hi;
    logic        tbl_rd;
    logic [7:0]  tbl_page;
    logic [15:0] tbl_addr;
    logic [15:0] tbl_wdata;
    logic        sfr_wr;
    logic        sfr_sel;
    logic [15:0] sfr_wdata;
    logic        stall;
    logic [15:0] ctrl_rdata;
    logic [23:0] tbl_rdata;

    modport dev (input tbl_wr_lo, tbl_wr_hi, tbl_rd, tbl_page, tbl_addr, tbl_wdata,
                 input sfr_wr, sfr_sel, sfr_wdata,
                 output stall, ctrl_rdata, tbl_rdata);
    modport cpu (output tbl_wr_lo, tbl_wr_hi, tbl_rd, tbl_page, tbl_addr, tbl_wdata,
                 output sfr_wr, sfr_sel, sfr_wdata,
                 input stall, ctrl_rdata, tbl_rdata);
endinterface : fsps_if

// >>> fsps_flash_dev.sv
/*
 * flash self-programming sequencer: holding buffer, unlock key, control
 * register, timed erase/program of a small flash array, processor stall.
 * assumes the processor end keeps to the link pulses and the osc_tick
 * input strobes once per internal fast rc oscillator cycle, synchronous.
 */
`timescale 1ns/1ps
module fsps_flash_dev
    import fsps_pkg::*;
#(
    parameter int ROW_WRITE_CYCLES  = fsps_pkg::ROW_WRITE_OSC_CYCLES,
    parameter int PAGE_ERASE_CYCLES = fsps_pkg::PAGE_ERASE_OSC_CYCLES,
    parameter int WORD_WRITE_CYCLES = fsps_pkg::WORD_WRITE_OSC_CYCLES
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // processor link
    fsps_if.dev       cpu,
    // oscillator strobe and status
    input  wire logic osc_tick,
    output logic      flash_busy
);
    import fsps_pkg::*;

    logic [WORD_W-1:0]      flash_mem [FLASH_INSTRS];
    logic [WORD_W-1:0]      hold_buf  [ROW_INSTRS];
    logic [ROW_INSTRS-1:0]  buf_valid;
    logic [DATA_W-1:0]      ctrl;
    fsps_key_t              key;
    fsps_dev_state_t        state;
    logic [CTRL_OP_W-1:0]   op;
    logic [FLASH_IDX_W-1:0] tgt_idx;
    logic                   tgt_user;
    logic [FLASH_IDX_W-1:0] walk_idx;
    logic [WALK_W-1:0]      walk_left;
    logic [TIMER_W-1:0]     osc_cnt;
    logic                   stall;
    logic [WORD_W-1:0]      tbl_rdata;
    fsps_key_t              next_key;

    // address forming and decode
    wire [WORD_W-1:0]      prog_addr = {cpu.tbl_page, cpu.tbl_addr};
    wire [FLASH_IDX_W-1:0] instr_idx = prog_addr[FLASH_IDX_W:1];
    wire                   in_user   = (prog_addr[WORD_W-1:FLASH_IDX_W+1] == '0);
    wire [BUF_IDX_W-1:0]   buf_idx   = cpu.tbl_addr[BUF_IDX_W:1];
    wire                   idle      = (state == D_IDLE);
    wire                   tbl_wr    = idle & (cpu.tbl_wr_lo | cpu.tbl_wr_hi);
    wire                   key_wr    = cpu.sfr_wr & (cpu.sfr_sel == SFR_SEL_KEY);
    wire                   ctrl_wr   = idle & cpu.sfr_wr & (cpu.sfr_sel == SFR_SEL_CTRL);
    wire [CTRL_OP_W-1:0]   req_op    = cpu.sfr_wdata[CTRL_OP_LSB +: CTRL_OP_W];
    wire                   op_known  = (req_op == OP_ROW) | (req_op == OP_ERASE)
                                       | (req_op == OP_WORD);
    wire                   start_req = ctrl_wr & cpu.sfr_wdata[CTRL_START_BIT]
                                       & cpu.sfr_wdata[CTRL_ENABLE_BIT]
                                       & op_known & (key == KEY_ARMED);

    // operation extent, aligned to its row or page
    wire [FLASH_IDX_W-1:0] start_base =
        (req_op == OP_ERASE) ? (tgt_idx & ~PAGE_MASK) :
        (req_op == OP_ROW)   ? (tgt_idx & ~ROW_MASK)  : tgt_idx;
    wire [WALK_W-1:0]      start_len  =
        (req_op == OP_ERASE) ? WALK_W'(PAGE_INSTRS) :
        (req_op == OP_ROW)   ? WALK_W'(ROW_INSTRS)  : WALK_W'(1);

    // operation length in oscillator cycles
    wire [TIMER_W-1:0] time_target =
        (op == OP_ERASE) ? TIMER_W'(PAGE_ERASE_CYCLES) :
        (op == OP_WORD)  ? TIMER_W'(WORD_WRITE_CYCLES) :
                           TIMER_W'(ROW_WRITE_CYCLES);
    wire walk_done = (walk_left == '0);
    wire time_done = (osc_cnt >= time_target);
    wire running   = (state == D_RUN);
    wire op_done   = running & walk_done & time_done;
    wire walking   = running & ~walk_done;

    // word presented to the array; unloaded entries leave bits erased
    wire [BUF_IDX_W-1:0] walk_buf  = walk_idx[BUF_IDX_W-1:0];
    wire [WORD_W-1:0]    prog_word = buf_valid[walk_buf] ? hold_buf[walk_buf] : ERASED_WORD;

    assign cpu.stall      = stall;
    assign cpu.ctrl_rdata = ctrl;
    assign cpu.tbl_rdata  = tbl_rdata;

    // unlock key: any other access between the keys and the start relocks
    always_comb begin
        next_key = key;
        if (key_wr) begin
            if (cpu.sfr_wdata[7:0] == KEY_FIRST)
                next_key = KEY_GOT_FIRST;
            else if ((cpu.sfr_wdata[7:0] == KEY_SECOND) && (key == KEY_GOT_FIRST))
                next_key = KEY_ARMED;
            else
                next_key = KEY_LOCKED;
        end else if (cpu.sfr_wr | cpu.tbl_wr_lo | cpu.tbl_wr_hi | cpu.tbl_rd) begin
            next_key = KEY_LOCKED;
        end
    end

    // holding buffer, filled by word then byte
    always_ff @(posedge aclk) begin
        if (tbl_wr & cpu.tbl_wr_lo)
            hold_buf[buf_idx][DATA_W-1:0] <= cpu.tbl_wdata;
        if (tbl_wr & cpu.tbl_wr_hi)
            hold_buf[buf_idx][WORD_W-1:DATA_W] <= cpu.tbl_wdata[7:0];
    end

    // array: erase sets bits, programming only clears them
    always_ff @(posedge aclk) begin
        if (walking & tgt_user) begin
            if (op == OP_ERASE)
                flash_mem[walk_idx] <= ERASED_WORD;
            else
                flash_mem[walk_idx] <= flash_mem[walk_idx] & prog_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_valid <= '0;
            tgt_idx   <= '0;
            tgt_user  <= 1'b0;
            tbl_rdata <= '0;
        end else begin
            if (op_done && (op != OP_ERASE))
                buf_valid <= '0;
            else if (tbl_wr & cpu.tbl_wr_hi)
                buf_valid[buf_idx] <= 1'b1;
            if (tbl_wr) begin
                tgt_idx  <= instr_idx;
                tgt_user <= in_user;
            end
            if (cpu.tbl_rd)
                tbl_rdata <= in_user ? flash_mem[instr_idx] : '0;
        end
    end

    // key, control register, stall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key   <= KEY_LOCKED;
            ctrl  <= CTRL_RESET;
            stall <= 1'b0;
        end else begin
            key <= next_key;
            if (ctrl_wr) begin
                ctrl[CTRL_START_BIT-1:0] <= cpu.sfr_wdata[CTRL_START_BIT-1:0];
                ctrl[CTRL_START_BIT]     <= start_req;
            end else if (op_done) begin
                ctrl[CTRL_START_BIT]     <= 1'b0;
            end
            // one stall cycle per buffer write, whole operation otherwise
            stall <= idle ? (start_req | tbl_wr) : ~op_done;
        end
    end

    // operation sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= D_IDLE;
            op         <= OP_ROW;
            walk_idx   <= '0;
            walk_left  <= '0;
            osc_cnt    <= '0;
            flash_busy <= 1'b0;
        end else begin
            if (idle & start_req) begin
                state      <= D_RUN;
                op         <= req_op;
                walk_idx   <= start_base;
                walk_left  <= start_len;
                osc_cnt    <= '0;
                flash_busy <= 1'b1;
            end else if (op_done) begin
                state      <= D_IDLE;
                flash_busy <= 1'b0;
            end else if (running) begin
                if (!walk_done) begin
                    walk_idx  <= walk_idx + FLASH_IDX_W'(1);
                    walk_left <= walk_left - WALK_W'(1);
                end
                if (osc_tick & ~time_done)
                    osc_cnt <= osc_cnt + TIMER_W'(1);
            end
        end
    end
endmodule : fsps_flash_dev

// >>> fsps_cpu_ctl.sv
/*
 * processor-side controller: takes commands over AXI4-Lite and plays them
 * onto the flash link as table writes, table reads, key writes and control writes.
 * assumes the flash end answers with stall as documented in the link.
 */
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module fsps_cpu_ctl (
    // clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // axi4-lite write
    input  wire logic [fsps_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    // axi4-lite read
    input  wire logic [fsps_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    // flash link
    fsps_if.cpu                                  cpu
);
    import fsps_pkg::*;

    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0]           w_data;
    logic                  aw_got;
    logic                  w_got;
    logic [WORD_W-1:0]     addr_q;
    logic [DATA_W-1:0]     data_q;
    logic [WORD_W-1:0]     rd_q;
    fsps_cmd_t             cmd_q;
    fsps_host_state_t      state;
    logic [1:0]            step;
    logic [1:0]            nop_cnt;
    fsps_cmd_t             cur_op;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_fire = aw_got & w_got & ~s_axi_bvalid;
    wire wr_ok   = (aw_addr == REG_CMD) | (aw_addr == REG_ADDR) | (aw_addr == REG_DATA);
    wire rd_ok   = (s_axi_araddr == REG_ADDR) | (s_axi_araddr == REG_DATA)
                   | (s_axi_araddr == REG_STATUS) | (s_axi_araddr == REG_RDATA)
                   | (s_axi_araddr == REG_CTRL);
    wire [31:0] rd_mux =
        (s_axi_araddr == REG_ADDR)   ? {8'h00, addr_q} :
        (s_axi_araddr == REG_DATA)   ? {16'h0000, data_q} :
        (s_axi_araddr == REG_STATUS) ? {30'h0, cpu.stall, state != H_IDLE} :
        (s_axi_araddr == REG_RDATA)  ? {8'h00, rd_q} :
        (s_axi_araddr == REG_CTRL)   ? {16'h0000, cpu.ctrl_rdata} : 32'h0;
    wire       cmd_wr  = wr_fire & (aw_addr == REG_CMD) & (state == H_IDLE);
    fsps_cmd_t new_cmd;
    assign new_cmd = fsps_cmd_t'(w_data[2:0]);
    wire last_step = (cmd_q != CMD_UNLOCK_START) | (step == 2'd2);

    // unlock runs key, key, start back to back with nothing between
    always_comb begin
        cur_op = cmd_q;
        if (cmd_q == CMD_UNLOCK_START)
            cur_op = (step == 2'd2) ? CMD_CTRL : CMD_KEY;
    end

    assign cpu.tbl_page  = addr_q[WORD_W-1:DATA_W];
    assign cpu.tbl_addr  = addr_q[DATA_W-1:0];
    assign cpu.tbl_wdata = data_q;

    // axi write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= AXI_OKAY;
        end else begin
            if (aw_take) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got <= 1'b0;
            end
            if (w_take) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
            end else if (wr_fire) begin
                w_got <= 1'b0;
            end
            s_axi_awready <= ~(aw_got | aw_take) & ~s_axi_bvalid & ~wr_fire;
            s_axi_wready  <= ~(w_got | w_take) & ~s_axi_bvalid & ~wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= AXI_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // operand registers; byte strobes ignored, whole word taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= '0;
            data_q <= '0;
            rd_q   <= '0;
        end else begin
            if (wr_fire && (aw_addr == REG_ADDR))
                addr_q <= w_data[WORD_W-1:0];
            if (wr_fire && (aw_addr == REG_DATA))
                data_q <= w_data[DATA_W-1:0];
            if ((state == H_WAIT) && (cmd_q == CMD_TBL_RD))
                rd_q <= cpu.tbl_rdata;
        end
    end

    // link sequencer: issue, let the pulse land, wait out the stall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= H_IDLE;
            cmd_q   <= CMD_NONE;
            step    <= '0;
            nop_cnt <= '0;
            cpu.tbl_wr_lo <= 1'b0;
            cpu.tbl_wr_hi <= 1'b0;
            cpu.tbl_rd    <= 1'b0;
            cpu.sfr_wr    <= 1'b0;
            cpu.sfr_sel   <= SFR_SEL_CTRL;
            cpu.sfr_wdata <= '0;
        end else begin
            cpu.tbl_wr_lo <= 1'b0;
            cpu.tbl_wr_hi <= 1'b0;
            cpu.tbl_rd    <= 1'b0;
            cpu.sfr_wr    <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    if (cmd_wr && (new_cmd != CMD_NONE)) begin
                        cmd_q <= new_cmd;
                        step  <= '0;
                        state <= H_ISSUE;
                    end
                end
                H_ISSUE: begin
                    cpu.tbl_wr_lo <= (cur_op == CMD_TBL_LO);
                    cpu.tbl_wr_hi <= (cur_op == CMD_TBL_HI);
                    cpu.tbl_rd    <= (cur_op == CMD_TBL_RD);
                    cpu.sfr_wr    <= (cur_op == CMD_CTRL) | (cur_op == CMD_KEY);
                    cpu.sfr_sel   <= (cur_op == CMD_KEY) ? SFR_SEL_KEY : SFR_SEL_CTRL;
                    if (cmd_q != CMD_UNLOCK_START)
                        cpu.sfr_wdata <= data_q;
                    else if (step == 2'd0)
                        cpu.sfr_wdata <= {8'h00, KEY_FIRST};
                    else if (step == 2'd1)
                        cpu.sfr_wdata <= {8'h00, KEY_SECOND};
                    else
                        cpu.sfr_wdata <= {1'b1, data_q[CTRL_START_BIT-1:0]};
                    state <= H_SETTLE;
                end
                H_SETTLE: state <= H_WAIT;
                H_WAIT: begin
                    if (!cpu.stall) begin
                        if (!last_step) begin
                            step  <= step + 2'd1;
                            state <= H_ISSUE;
                        end else if (cmd_q == CMD_UNLOCK_START) begin
                            nop_cnt <= 2'(NOP_AFTER_START - 1);
                            state   <= H_NOP;
                        end else begin
                            state <= H_IDLE;
                        end
                    end
                end
                H_NOP: begin
                    if (nop_cnt == '0)
                        state <= H_IDLE;
                    else
                        nop_cnt <= nop_cnt - 2'd1;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule : fsps_cpu_ctl

// >>> fsps_asserts.sv
/* link checker for the flash sequencer; assumes one clock shared by both ends */
`timescale 1ns/1ps
module fsps_asserts
    import fsps_pkg::*;
#(parameter int ROW_CYC = 600) (
    input wire logic        aclk, aresetn, tbl_wr_lo, tbl_wr_hi, tbl_rd,
    input wire logic        sfr_wr, sfr_sel, stall,
    input wire logic [15:0] sfr_wdata, ctrl_rdata
);
    logic        g55, armed;
    logic [15:0] n;
    wire acc = sfr_wr | tbl_wr_lo | tbl_wr_hi | tbl_rd;
    wire key = sfr_wr & sfr_sel;
    wire go  = sfr_wr & !sfr_sel & sfr_wdata[15] & sfr_wdata[14];
    wire [3:0] op = ctrl_rdata[3:0];
    // unlock tracking and stall length
    always_ff @(posedge aclk) begin
        if (!aresetn || acc) begin
            g55   <= aresetn & key & (sfr_wdata[7:0] == KEY_FIRST);
            armed <= aresetn & g55 & key & (sfr_wdata[7:0] == KEY_SECOND);
        end
        n <= (!aresetn || !stall) ? 16'h0 : n + 16'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_blip; stall ##1 !stall; endsequence
    a_tbl_two_cyc: assert property ((tbl_wr_lo | tbl_wr_hi) |=> s_blip)
        else $error("table write stall not one cycle");
    a_start_stalls: assert property (go & armed |=> stall & ctrl_rdata[15])
        else $error("unlocked start did not stall");
    a_bad_start: assert property (go & !armed |=> !stall & !ctrl_rdata[15])
        else $error("start without keys accepted");
    a_key_quiet: assert property (key |=> !stall)
        else $error("key write stalled");
    a_bit_held: assert property (stall & $past(stall) |-> ctrl_rdata[15])
        else $error("start bit low during operation");
    a_bit_clears: assert property ($fell(ctrl_rdata[15]) |-> $fell(stall))
        else $error("start bit clear not with stall end");
    a_row_time: assert property ($fell(ctrl_rdata[15]) && op == OP_ROW |->
        n >= ROW_CYC - 3 && n <= ROW_CYC + 4)
        else $error("row write length wrong");
    a_erase_walk: assert property ($fell(ctrl_rdata[15]) && op == OP_ERASE |->
        n >= PAGE_INSTRS)
        else $error("erase shorter than page walk");
endmodule : fsps_asserts

// >>> tb_flash_self_program_sequencer.sv
/* self-checking bench for both ends; assumes the controller's AXI map and link timing */
`timescale 1ns/1ps
module tb_flash_self_program_sequencer;
    import fsps_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, lfsr = 32'h1e8a;
    logic [1:0]  rs;
    logic        tick = 1'b1;
    logic [23:0] mem [64];
    wire awready, wready, bvalid, arready, rvalid, busy;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    int mismatches = 0, compares = 0;
    fsps_if lnk ();
    fsps_flash_dev #(.ROW_WRITE_CYCLES(600), .PAGE_ERASE_CYCLES(600), .WORD_WRITE_CYCLES(2))
        i_fsps_flash_dev (.aclk, .aresetn, .cpu(lnk), .osc_tick(tick), .flash_busy(busy));
    fsps_cpu_ctl i_fsps_cpu_ctl (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu(lnk));
    fsps_asserts #(.ROW_CYC(600)) i_fsps_asserts (.aclk, .aresetn, .tbl_wr_lo(lnk.tbl_wr_lo),
        .tbl_wr_hi(lnk.tbl_wr_hi), .tbl_rd(lnk.tbl_rd), .sfr_wr(lnk.sfr_wr),
        .sfr_sel(lnk.sfr_sel), .stall(lnk.stall), .sfr_wdata(lnk.sfr_wdata),
        .ctrl_rdata(lnk.ctrl_rdata));
    initial forever #20 aclk = ~aclk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1; pw = 1;
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) pa = 0;
            if (wready) pw = 0;
            awv <= pa; wv <= pw;
        end while (pa | pw);
        do @(posedge aclk); while (!bvalid);
        rs = bresp; bready <= 0;
        @(posedge aclk);
    endtask : wr
    task automatic rd_(input logic [7:0] a);
        araddr <= a; arv <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arv <= 0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata; rs = rresp; rready <= 0;
        @(posedge aclk);
    endtask : rd_
    task automatic cmd(input logic [2:0] c, input logic [23:0] d);
        wr(REG_DATA, 32'(d));
        wr(REG_CMD, 32'(c));
        do rd_(REG_STATUS); while (rd[0] !== 1'b0);
    endtask : cmd
    task automatic tw(input logic [23:0] a, input logic [23:0] w);
        wr(REG_ADDR, 32'(a));
        cmd(3'd1, 24'(w[15:0]));
        cmd(3'd2, 24'(w[23:16]));
    endtask : tw
    task automatic rw(input logic [23:0] a, input logic [23:0] e);
        wr(REG_ADDR, 32'(a));
        cmd(3'd5, 24'h0);
        rd_(REG_RDATA);
        chk(rd, 32'(e));
    endtask : rw
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd_(REG_CTRL); chk(rd, 32'h0);
        wr(8'h40, lfsr); chk(32'(rs), 32'(AXI_SLVERR));
        rd_(8'h44); chk(32'(rs), 32'(AXI_SLVERR));
        wr(REG_ADDR, 32'h0); cmd(3'd1, 24'h0);
        cmd(3'd6, 24'h4002);
        rw(24'h000, ERASED_WORD); rw(24'h3fe, ERASED_WORD);
        for (int i = 0; i < ROW_INSTRS; i++) begin
            lfsr = nxt(lfsr);
            mem[i] = lfsr[23:0];
            tw(24'h80 + 24'(2 * i), mem[i]);
        end
        cmd(3'd6, 24'h4001);
        for (int i = 0; i < ROW_INSTRS; i++) rw(24'h80 + 24'(2 * i), mem[i]);
        rw(24'h07e, ERASED_WORD); rw(24'h100, ERASED_WORD);
        wr(REG_ADDR, 32'h100); cmd(3'd1, 24'h0); cmd(3'd6, 24'h4001);
        rw(24'h100, ERASED_WORD);
        lfsr = nxt(lfsr);
        tw(24'h180, lfsr[23:0]);
        // oscillator held still: word write must wait with the processor stalled
        tick <= 1'b0;
        wr(REG_DATA, 32'h4003);
        wr(REG_CMD, 32'h6);
        chk(32'(rs), 32'(AXI_OKAY));
        repeat (40) @(posedge aclk);
        rd_(REG_STATUS);
        chk(rd, 32'h3);
        chk(32'(rs), 32'(AXI_OKAY));
        chk(32'(busy), 32'h1);
        tick <= 1'b1;
        do rd_(REG_STATUS); while (rd[0] !== 1'b0);
        chk(32'(busy), 32'h0);
        rw(24'h180, lfsr[23:0]); rw(24'h182, ERASED_WORD);
        cmd(3'd4, 24'h55); cmd(3'd4, 24'haa); cmd(3'd1, 24'h0); cmd(3'd3, 24'hc001);
        rd_(REG_CTRL); chk(rd, 32'h4001);
        report_and_stop;
    end
    // run needs about 5600 cycles; allow about seven times that
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        report_and_stop;
    end
endmodule : tb_flash_self_program_sequencer
